/* File: src/sdimb_beat_if.sv */
// interface carrying burst beats from the sequencer into the fifo
`timescale 1ns/1ps
`default_nettype none
interface sdimb_beat_if #(parameter int WIDTH = 26);
  logic             valid;  // beat present
  logic             ready;  // sink can take it
  logic [WIDTH-1:0] data;   // packed beat
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: src/sdimb_core.sv */
// sdram power-on checker, mode register and burst column generator
//
// What this block does
// - mode load accepted before or after refreshes
// - mode load captures all twelve address bits
// - fields: options, latency, order, length
// - beats tagged with read latency 2 or 3
// - length codes 1,2,4,8, full page sequential
// - order bit selects sequential or interleaved
// - options zero give burst read and write
// - single-write option writes one column only
// - first write beat on command clock
// - start column given, rest generated internally
// - sequential wraps inside aligned block
// - interleaved xors beat count into low bits
// - full page walks 256 columns wrapping
// - precharge a10 high closes both banks
`timescale 1ns/1ps
`default_nettype none
module sdimb_core #(
  parameter int STAB_CYCLES = sdimb_pkg::STAB_CYC,
  parameter int FIFO_DEPTH  = 16
) (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          cs_n_in,
  input  wire logic                          ras_n_in,
  input  wire logic                          cas_n_in,
  input  wire logic                          we_n_in,
  input  wire logic                          clk_gate_in,
  input  wire logic [1:0]                    byte_mask_in,
  input  wire logic [sdimb_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic                          beat_ready_in,
  output logic                               beat_valid_out,
  output logic                               beat_write_out,
  output logic                               beat_bank_out,
  output logic [sdimb_pkg::COL_W-1:0]        beat_col_out,
  output logic [2:0]                         beat_lat_out,
  output logic                               beat_last_out,
  output logic [sdimb_pkg::ADDR_W-1:0]       mode_out,
  output logic [1:0]                         bank_open_out,
  output logic                               ready_out,
  output logic                               busy_out,
  output logic                               seq_err_out,
  output logic                               mode_bad_out
);
  import sdimb_pkg::*;

  initial begin
    if (STAB_CYCLES < 1) $error("stabilisation count must be positive");
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end

  // -----------------------------------------
  // command decode
  // -----------------------------------------
  localparam int BEAT_W = 1 + 1 + COL_W + 3 + 1;  // write, bank, col, lat, last
  sdimb_cmd_t cmd;           // decoded command this clock
  logic       is_mode;       // mode load strobe
  logic       is_pre;
  logic       is_ref;
  logic       is_act;
  logic       is_rd;
  logic       is_wr;
  logic       is_nop;        // nop, deselect or ras/cas high with we low
  assign cmd     = cs_n_in ? SDIMB_CMD_NOP
                 : sdimb_cmd_t'({1'b0, ras_n_in, cas_n_in, we_n_in});
  assign is_mode = (cmd == SDIMB_CMD_MODE);
  assign is_pre  = (cmd == SDIMB_CMD_PRE);
  assign is_ref  = (cmd == SDIMB_CMD_REF);
  assign is_act  = (cmd == SDIMB_CMD_ACT);
  assign is_rd   = (cmd == SDIMB_CMD_READ);
  assign is_wr   = (cmd == SDIMB_CMD_WRITE);
  assign is_nop  = (cmd == SDIMB_CMD_NOP) || (!cs_n_in && ras_n_in && cas_n_in && !we_n_in);

  // -----------------------------------------
  // mode register and field decode
  // -----------------------------------------
  logic [ADDR_W-1:0] mode_reg;   // loaded op code
  logic [4:0]        opt_field;
  logic [2:0]        read_latency_field;
  logic              burst_order_bit;
  logic [2:0]        burst_count_field;
  logic              mode_ok;    // candidate value is legal
  logic              lat_ok;
  logic              len_ok;
  logic              opt_ok;
  assign opt_field          = mode_reg[MODE_OPT_HI:MODE_OPT_LO];
  assign read_latency_field = mode_reg[MODE_LAT_HI:MODE_LAT_LO];
  assign burst_order_bit    = mode_reg[MODE_ORD_BIT];
  assign burst_count_field  = mode_reg[MODE_LEN_HI:MODE_LEN_LO];
  // legality of the value on the pins at a mode load
  assign lat_ok  = (addr_in[MODE_LAT_HI:MODE_LAT_LO] == LAT_2)
                || (addr_in[MODE_LAT_HI:MODE_LAT_LO] == LAT_3);
  assign len_ok  = (addr_in[MODE_LEN_HI:MODE_LEN_LO] <= LEN_8)
                || (addr_in[MODE_LEN_HI:MODE_LEN_LO] == LEN_FULL
                    && !addr_in[MODE_ORD_BIT]);
  assign opt_ok  = (addr_in[MODE_OPT_HI:MODE_OPT_LO] == OPT_BURST_WR)
                || (addr_in[MODE_OPT_HI:MODE_OPT_LO] == OPT_SINGLE_WR);
  assign mode_ok = lat_ok && len_ok && opt_ok;

  // -----------------------------------------
  // bank state: track open rows
  // -----------------------------------------
  logic [1:0] bank_open;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_open <= 2'h0;
    end else if (is_act) begin
      bank_open[addr_in[BANK_BIT]] <= 1'b1;
    end else if (is_pre) begin
      if (addr_in[ALLBANK_BIT]) begin
        bank_open <= 2'h0;
      end else begin
        bank_open[addr_in[BANK_BIT]] <= 1'b0;
      end
    end
  end

  // -----------------------------------------
  // power-on stabilisation: pins come from outside, three-stage sync
  // -----------------------------------------
  logic [2:0] gate_sync;   // gate and both masks anded, then synced
  logic       stab_level;  // agreed level of the stage pair
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_sync  <= 3'h0;
      stab_level <= 1'b0;
    end else begin
      gate_sync <= {gate_sync[1:0], clk_gate_in & (&byte_mask_in)};
      if (gate_sync[2] == gate_sync[1]) begin
        stab_level <= gate_sync[2];
      end
    end
  end

  // -----------------------------------------
  // init sequencer
  // -----------------------------------------
  sdimb_init_t       init_st;
  logic [31:0]       stab_cnt;   // cycles with pins held high
  logic [1:0]        ref_cnt;    // saturating init refresh count
  logic              mode_done;  // mode loaded during init
  logic [1:0]        wait_cnt;   // post mode-load gap
  logic              seq_err;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stab_cnt <= 32'h0;
    end else if (!stab_level) begin
      stab_cnt <= 32'h0;
    end else if (stab_cnt < 32'(STAB_CYCLES)) begin
      stab_cnt <= stab_cnt + 32'h1;
    end
  end
  // advance on commands; any out-of-order command flags an error
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      init_st   <= SDIMB_ST_STAB;
      ref_cnt   <= 2'h0;
      mode_done <= 1'b0;
    end else begin
      case (init_st)
        SDIMB_ST_STAB: begin
          // masks must stay high for the whole wait
          if (!is_nop) begin
            init_st <= SDIMB_ST_ERROR;
          end else if (stab_cnt >= 32'(STAB_CYCLES)) begin
            init_st <= SDIMB_ST_PRE;
          end
        end
        SDIMB_ST_PRE: begin
          if (is_pre && addr_in[ALLBANK_BIT]) begin
            init_st <= SDIMB_ST_SETUP;
          end else if (!is_nop) begin
            init_st <= SDIMB_ST_ERROR;
          end
        end
        SDIMB_ST_SETUP: begin
          // refreshes and mode load in either order
          if (is_ref) begin
            if (ref_cnt != 2'h3) begin
              ref_cnt <= ref_cnt + 2'h1;
            end
          end else if (is_mode) begin
            mode_done <= 1'b1;
          end else if (!is_nop) begin
            init_st <= SDIMB_ST_ERROR;
          end
          if (mode_done && ref_cnt >= 2'(INIT_REF_MIN) && is_nop) begin
            init_st <= SDIMB_ST_READY;
          end
        end
        SDIMB_ST_READY: begin
          init_st <= SDIMB_ST_READY;
        end
        SDIMB_ST_ERROR: begin
          init_st <= SDIMB_ST_ERROR;
        end
        default: begin
          init_st <= SDIMB_ST_ERROR;
        end
      endcase
    end
  end
  // sticky violations: init error, mode load with open bank, command in gap
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_err <= 1'b0;
    end else if (init_st == SDIMB_ST_ERROR) begin
      seq_err <= 1'b1;
    end else if (is_mode && bank_open != 2'h0) begin
      seq_err <= 1'b1;
    end else if (wait_cnt != 2'h0 && !is_nop) begin
      seq_err <= 1'b1;
    end
  end

  // -----------------------------------------
  // mode load: capture, gap timer, legality flag
  // -----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= MODE_RESET;
    end else if (is_mode && bank_open == 2'h0) begin
      mode_reg <= addr_in;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt <= 2'h0;
    end else if (is_mode) begin
      wait_cnt <= 2'(MODE_WAIT_CYC - 1);
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
  // sticky: a mode load carried a reserved value, even one refused for an open bank
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_bad_out <= 1'b0;
    end else if (is_mode && !mode_ok) begin
      mode_bad_out <= 1'b1;
    end
  end

  // -----------------------------------------
  // burst column generator
  // -----------------------------------------
  sdimb_beat_if #(.WIDTH(BEAT_W)) beat_bus ();
  logic             active;     // burst in progress
  logic             b_write;
  logic             b_bank;
  logic [COL_W-1:0] b_start;    // column given with command
  logic [COL_W-1:0] b_idx;      // beat count
  logic [COL_W-1:0] b_left;     // beats still to generate, current one included
  logic [COL_W-1:0] len_mask;   // low bits that wrap
  logic [COL_W-1:0] cur_col;
  logic [COL_W-1:0] cmd_len_m1; // length minus one for a new burst
  logic             start;
  logic             stall;
  logic             full_page;
  assign stall     = !beat_bus.ready;
  assign full_page = (burst_count_field == LEN_FULL);
  // wrap mask per length; full page wraps over all 256 columns
  always_comb begin
    case (burst_count_field)
      LEN_1:    len_mask = 8'h00;
      LEN_2:    len_mask = 8'h01;
      LEN_4:    len_mask = 8'h03;
      LEN_8:    len_mask = 8'h07;
      LEN_FULL: len_mask = 8'hFF;
      default:  len_mask = 8'h00;
    endcase
  end
  // single-write option forces a one-beat write
  assign cmd_len_m1 = (is_wr && opt_field == OPT_SINGLE_WR) ? 8'h00 : len_mask;
  // sequential adds modulo the block, interleaved xors the count
  assign cur_col = burst_order_bit
                 ? (b_start ^ (b_idx & len_mask))
                 : ((b_start & ~len_mask) | ((b_start + b_idx) & len_mask));
  // a new read or write restarts the burst; stalls hold position
  assign start = (is_rd || is_wr) && (init_st == SDIMB_ST_READY);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active  <= 1'b0;
      b_write <= 1'b0;
      b_bank  <= 1'b0;
      b_start <= 8'h00;
      b_idx   <= 8'h00;
      b_left  <= 8'h00;
    end else if (start && !stall) begin
      // first beat goes out this clock, so the next index is one
      b_write <= is_wr;
      b_bank  <= addr_in[BANK_BIT];
      b_start <= addr_in[COL_W-1:0];
      b_idx   <= 8'h01;
      b_left  <= cmd_len_m1;
      active  <= (cmd_len_m1 != 8'h00);
    end else if (active && !stall) begin
      b_idx  <= b_idx + 8'h01;
      b_left <= b_left - 8'h01;
      active <= (b_left != 8'h01);
    end
  end
  // beat into fifo: the command beat itself, or a generated one
  assign beat_bus.valid = start || active;
  assign beat_bus.data  = start
    ? {is_wr, addr_in[BANK_BIT], addr_in[COL_W-1:0], read_latency_field,
       cmd_len_m1 == 8'h00}
    : {b_write, b_bank, cur_col, read_latency_field, b_left == 8'h01};

  // -----------------------------------------
  // output fifo and registered outputs
  // -----------------------------------------
  logic              f_valid;
  logic [BEAT_W-1:0] f_data;
  logic              f_take;
  sdimb_fifo #(.WIDTH(BEAT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .wr           (beat_bus),
    .rd_valid_out (f_valid),
    .rd_ready_in  (f_take),
    .rd_data_out  (f_data),
    .full_out     ()
  );
  // output stage register: refill when empty or being taken
  assign f_take = f_valid && (!beat_valid_out || beat_ready_in);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      beat_valid_out <= 1'b0;
      beat_write_out <= 1'b0;
      beat_bank_out  <= 1'b0;
      beat_col_out   <= 8'h00;
      beat_lat_out   <= 3'h0;
      beat_last_out  <= 1'b0;
    end else if (!beat_valid_out || beat_ready_in) begin
      beat_valid_out <= f_valid;
      {beat_write_out, beat_bank_out, beat_col_out, beat_lat_out, beat_last_out} <= f_data;
    end
  end
  // status outputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_out      <= MODE_RESET;
      bank_open_out <= 2'h0;
      ready_out     <= 1'b0;
      busy_out      <= 1'b0;
      seq_err_out   <= 1'b0;
    end else begin
      mode_out      <= mode_reg;
      bank_open_out <= bank_open;
      ready_out     <= (init_st == SDIMB_ST_READY);
      busy_out      <= active || full_page && start;
      seq_err_out   <= seq_err;
    end
  end
endmodule
`default_nettype wire

/* File: src/sdimb_fifo.sv */
// parameterised valid/ready fifo for burst beats
`timescale 1ns/1ps
`default_nettype none
module sdimb_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  sdimb_beat_if.snk         wr,
  output logic              rd_valid_out,
  input  wire logic         rd_ready_in,
  output logic [WIDTH-1:0]  rd_data_out,
  output logic              full_out
);
  // -----------------------------------------
  // storage and pointers
  // -----------------------------------------
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];  // beat storage
  logic [AW:0]      wptr;         // write pointer with wrap bit
  logic [AW:0]      rptr;         // read pointer with wrap bit
  logic             do_wr;
  logic             do_rd;
  logic             empty;
  assign empty        = (wptr == rptr);
  assign full_out     = (wptr[AW-1:0] == rptr[AW-1:0]) && (wptr[AW] != rptr[AW]);
  assign wr.ready     = !full_out;
  assign do_wr        = wr.valid && !full_out;
  assign rd_valid_out = !empty;
  assign do_rd        = rd_ready_in && !empty;
  assign rd_data_out  = mem[rptr[AW-1:0]];
  // write side
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wptr <= '0;
    end else if (do_wr) begin
      wptr <= wptr + 1'b1;
    end
  end
  // storage has no reset; reads only valid entries
  always_ff @(posedge mclk_in) begin
    if (do_wr) begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end
  // read side
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rptr <= '0;
    end else if (do_rd) begin
      rptr <= rptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: src/sdimb_pkg.sv */
// shared constants and types for the sdram init / mode / burst block
package sdimb_pkg;
  // widths
  localparam int ADDR_W = 12;
  localparam int COL_W  = 8;
  localparam int DATA_W = 16;
  // mode register field positions
  localparam int MODE_OPT_HI  = 11;
  localparam int MODE_OPT_LO  = 7;
  localparam int MODE_LAT_HI  = 6;
  localparam int MODE_LAT_LO  = 4;
  localparam int MODE_ORD_BIT = 3;
  localparam int MODE_LEN_HI  = 2;
  localparam int MODE_LEN_LO  = 0;
  localparam int BANK_BIT     = 11;
  localparam int ALLBANK_BIT  = 10;
  localparam logic [11:0] MODE_RESET = 12'h000;
  // field encodings
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [2:0] LEN_1 = 3'h0;
  localparam logic [2:0] LEN_2 = 3'h1;
  localparam logic [2:0] LEN_4 = 3'h2;
  localparam logic [2:0] LEN_8 = 3'h3;
  localparam logic [2:0] LEN_FULL = 3'h7;
  localparam logic [4:0] OPT_BURST_WR  = 5'h00;
  localparam logic [4:0] OPT_SINGLE_WR = 5'h04;
  // timing
  localparam int CLK_MHZ        = 200;
  localparam int STAB_US        = 100;
  localparam int STAB_CYC       = STAB_US * CLK_MHZ;
  localparam int MODE_WAIT_CYC  = 2;
  localparam int INIT_REF_MIN   = 2;
  // command codes {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDIMB_CMD_NOP   = 4'h7,
    SDIMB_CMD_READ  = 4'h5,
    SDIMB_CMD_WRITE = 4'h4,
    SDIMB_CMD_ACT   = 4'h3,
    SDIMB_CMD_PRE   = 4'h2,
    SDIMB_CMD_REF   = 4'h1,
    SDIMB_CMD_MODE  = 4'h0
  } sdimb_cmd_t;
  // init progress
  typedef enum logic [2:0] {
    SDIMB_ST_STAB  = 3'h0,
    SDIMB_ST_PRE   = 3'h1,
    SDIMB_ST_SETUP = 3'h2,
    SDIMB_ST_READY = 3'h3,
    SDIMB_ST_ERROR = 3'h4
  } sdimb_init_t;
endpackage

/* File: tb/sdimb_core_asserts.sv */
// port assertions for the sdram init / mode / burst block
`timescale 1ns/1ps
`default_nettype none
module sdimb_core_asserts #(
  parameter int STAB_CYCLES = 20,
  parameter int FIFO_DEPTH  = 16
) (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        cs_n_in,
  input wire logic        ras_n_in,
  input wire logic        cas_n_in,
  input wire logic        we_n_in,
  input wire logic [11:0] addr_in,
  input wire logic        beat_ready_in,
  input wire logic        beat_valid_out,
  input wire logic        beat_write_out,
  input wire logic [7:0]  beat_col_out,
  input wire logic [2:0]  beat_lat_out,
  input wire logic [11:0] mode_out,
  input wire logic [1:0]  bank_open_out,
  input wire logic        ready_out,
  input wire logic        busy_out,
  input wire logic        seq_err_out,
  input wire logic        mode_bad_out
);
  import sdimb_pkg::*;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [3:0] cmd;  // command pins as one code
  int         cyc;  // cycles since reset, saturates past the wait
  assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  // saturate so a long run never wraps the count
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc <= 0;
    end else if (cyc <= STAB_CYCLES) begin
      cyc <= cyc + 1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  quiet_reset_a: assert property ($rose(rst_n_in) |-> !ready_out && !seq_err_out)
    else $error("status set right after reset");
  stab_wait_a: assert property (ready_out |-> cyc >= STAB_CYCLES)
    else $error("ready before the stabilisation wait");
  mode_capture_a: assert property ((cmd == SDIMB_CMD_MODE && ready_out && bank_open_out == 2'h0
    && $past(cmd) != SDIMB_CMD_MODE) |-> ##2 mode_out == $past(addr_in, 2))
    else $error("mode load not captured");
  // mode_out trails the register by one clock, so the clock after a load is skipped
  mode_hold_a: assert property (cmd != SDIMB_CMD_MODE && $past(cmd) != SDIMB_CMD_MODE
    |=> $stable(mode_out))
    else $error("mode changed without a load");
  read_lat_a: assert property (beat_valid_out |-> beat_lat_out == mode_out[6:4])
    else $error("beat latency differs from mode");
  bad_len_a: assert property ((mode_out[2:0] inside {3'h4, 3'h5, 3'h6})
    || (mode_out[3] && mode_out[2:0] == LEN_FULL) |-> ##[0:1] mode_bad_out)
    else $error("reserved length not flagged");
  gap_err_a: assert property (cmd == SDIMB_CMD_MODE ##1 cmd < 4'h7 |=> ##1 seq_err_out)
    else $error("command in mode gap not flagged");
  beat_hold_a: assert property (beat_valid_out && !beat_ready_in |=> beat_valid_out
    && $stable(beat_col_out) && $stable(beat_write_out))
    else $error("beat dropped while stalled");
  first_beat_a: assert property (cmd == SDIMB_CMD_READ && ready_out && !busy_out
    && !beat_valid_out |-> ##[1:3] beat_valid_out)
    else $error("first beat late");
  pre_all_a: assert property (cmd == SDIMB_CMD_PRE && addr_in[10] |-> ##[1:2] !bank_open_out)
    else $error("precharge all left a bank open");
endmodule
`default_nettype wire

/* File: tb/sdimb_core_test.sv */
// self-checking bench for the sdram init / mode / burst block
`timescale 1ns/1ps
`default_nettype none
bind sdimb_core sdimb_core_asserts #(.STAB_CYCLES(STAB_CYCLES), .FIFO_DEPTH(FIFO_DEPTH))
  chk (.*);
module sdimb_core_test;
  import sdimb_pkg::*;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  localparam int STAB = 20;  // short wait keeps the run brief
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        rdy   = 1'b1;  // consumer ready, randomly stalled
  logic [3:0]  cmd;
  logic        gate, bv, bw, bb, bl, busy, rd, serr, mbad;
  logic [1:0]  mask, bo;
  logic [11:0] addr, mode;
  logic [7:0]  bc;
  logic [10:0] expq[$];  // notes {write, bank, last, column}
  int          num_errors = 0;
  int          compares   = 0;
  integer      seed       = 32'h9f08;
  int          i, j;
  always #2.5 clk = ~clk;
  sdimb_ctrl_model ctl (.mclk_in(clk), .cmd_out(cmd), .gate_out(gate), .mask_out(mask),
    .addr_out(addr));
  sdimb_core #(.STAB_CYCLES(STAB)) uut (.mclk_in(clk), .rst_n_in(rst_n), .cs_n_in(cmd[3]),
    .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .clk_gate_in(gate),
    .byte_mask_in(mask), .addr_in(addr), .beat_ready_in(rdy), .beat_valid_out(bv),
    .beat_write_out(bw), .beat_bank_out(bb), .beat_col_out(bc), .beat_lat_out(),
    .beat_last_out(bl), .mode_out(mode), .bank_open_out(bo), .ready_out(rd),
    .busy_out(busy), .seq_err_out(serr), .mode_bad_out(mbad));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one accepted beat: {write, bank, last, column}
  task automatic check_beat(input logic [10:0] got, input logic [10:0] exp);
    check({1'b0, got}, {1'b0, exp});
  endtask
  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait until every note is used and the generator is idle
  task automatic drain();
    for (int t = 0; t < 2000; t++) begin
      @(posedge clk);
      #2;
      if (expq.size() == 0 && busy === 1'b0 && bv === 1'b0) return;
    end
    num_errors++;
    $display("[ERR] %0t drain stuck %h", $time, expq.size());
    test_done();
  endtask
  // note the expected column order, then issue the command
  task automatic burst(input logic w, b, input logic [7:0] col, input int n, input logic il);
    logic [7:0] m;
    m = 8'(n - 1);
    for (int k = 0; k < n; k++)
      expq.push_back({w, b, k == n - 1, il ? col ^ 8'(k) : (col & ~m) | ((col + 8'(k)) & m)});
    ctl.cmd(w ? SDIMB_CMD_WRITE : SDIMB_CMD_READ, {b, 3'h0, col});
    drain();
  endtask
  task automatic setmode(input logic [11:0] m);
    ctl.cmd(SDIMB_CMD_MODE, m);
    @(posedge clk);
    #1 check(mode, m);
  endtask
  task automatic boot(input logic [11:0] m);
    ctl.init(STAB, m);
    for (i = 0; i < 20 && rd !== 1'b1; i++) @(posedge clk);
    #1 check({9'h000, rd, serr, mbad}, 12'h004);
    check(mode, m);
  endtask
  // ----------------------------------------
  // checking and stimulus
  // ----------------------------------------
  // each accepted beat against the oldest note; stalls picked at random
  always @(posedge clk) begin
    if (rst_n && bv === 1'b1 && rdy === 1'b1)
      check_beat({bw, bb, bl, bc}, expq.size() > 0 ? expq.pop_front() : 11'h7FF);
    #1 rdy = ($random(seed) % 4) != 0;
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    boot({OPT_BURST_WR, LAT_2, 1'b0, LEN_4});
    for (i = 0; i < 8; i++) begin
      setmode({OPT_BURST_WR, i[0] ? LAT_3 : LAT_2, i[2], 3'(i % 4)});
      for (j = 0; j < 2; j++)
        burst(j[0], 1'($random(seed)), 8'($random(seed)), 1 << (i % 4), i[2]);
    end
    setmode({OPT_BURST_WR, LAT_3, 1'b0, LEN_FULL});
    burst(1'b0, 1'b1, 8'hFD, 256, 1'b0);
    setmode({OPT_SINGLE_WR, LAT_2, 1'b1, LEN_8});
    burst(1'b1, 1'b0, 8'h13, 1, 1'b0);
    burst(1'b0, 1'b0, 8'h13, 8, 1'b1);
    setmode({OPT_BURST_WR, LAT_2, 1'b0, 3'h5});
    check({11'h000, mbad}, 12'h001);
    burst(1'b1, 1'b1, 8'h2A, 1, 1'b0);
    ctl.cmd(SDIMB_CMD_ACT, 12'h800);
    ctl.cmd(SDIMB_CMD_PRE, 12'h000);
    #1 check({10'h000, bo}, 12'h002);
    ctl.cmd(SDIMB_CMD_MODE, 12'h020);
    // the sticky flag reaches its output one clock after the refused load
    @(posedge clk);
    #1 check({serr, mode[10:0]}, 12'h825);
    ctl.cmd(SDIMB_CMD_PRE, 12'h400);
    @(posedge clk);
    #1 check({10'h000, bo}, 12'h000);
    // second reset clears the sticky flags, then a command inside the mode gap
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    boot(12'h039);
    ctl.cmd(SDIMB_CMD_MODE, 12'h039, 0);
    ctl.cmd(SDIMB_CMD_REF, 12'h000);
    @(posedge clk);
    #1 check({11'h000, serr}, 12'h001);
    // let the checker see the gap and capture properties complete
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire

/* File: tb/sdimb_ctrl_model.sv */
// controller model driving the command, level and address pins
`timescale 1ns/1ps
`default_nettype none
module sdimb_ctrl_model (
  input  wire logic   mclk_in,
  output logic [3:0]  cmd_out,
  output logic        gate_out,
  output logic [1:0]  mask_out,
  output logic [11:0] addr_out
);
  import sdimb_pkg::*;
  // ----------------------------------------
  // command issue
  // ----------------------------------------
  // deselected from time zero, gate and masks held high throughout
  initial begin
    cmd_out  = 4'hF;
    gate_out = 1'b1;
    mask_out = 2'h3;
    addr_out = 12'h000;
  end
  // one edge per command; stale address is inverted so it never looks valid
  task automatic cmd(input logic [3:0] c, input logic [11:0] a, input int nops = 1);
    @(posedge mclk_in);
    #1;
    cmd_out  = c;
    addr_out = a;
    repeat (nops) begin
      @(posedge mclk_in);
      #1;
      cmd_out  = SDIMB_CMD_NOP;
      addr_out = ~a;
    end
  endtask
  // power-up: wait, precharge both banks, refresh, mode load, refresh
  task automatic init(input int stab, input logic [11:0] m);
    repeat (stab + 4) @(posedge mclk_in);
    cmd(SDIMB_CMD_PRE, 12'h400);
    cmd(SDIMB_CMD_REF, 12'h000);
    cmd(SDIMB_CMD_MODE, m);
    cmd(SDIMB_CMD_REF, 12'h000);
  endtask
endmodule
`default_nettype wire
